// ===== core/chan_ctl_if.sv
// strobes and status between the register group and a channel unit
`timescale 1ns/1ps
interface chan_ctl_if;
    logic tx_rst;
    logic rx_rst;
    logic tx_en;
    logic rx_en;
    logic hold;
    logic tx_underrun_evt;
    logic tx_overflow_evt;
    logic rx_overflow_evt;
    logic tx_active;
    logic rx_active;
    logic tx_clear;
    logic rx_clear;
    logic tx_underrun_flag;
    logic tx_overflow_flag;
    logic rx_overflow_flag;

    modport regs (
        output tx_rst, rx_rst, tx_en, rx_en, hold,
        output tx_underrun_evt, tx_overflow_evt, rx_overflow_evt,
        input tx_active, rx_active, tx_clear, rx_clear,
        input tx_underrun_flag, tx_overflow_flag, rx_overflow_flag
    );
    modport unit (
        input tx_rst, rx_rst, tx_en, rx_en, hold,
        input tx_underrun_evt, tx_overflow_evt, rx_overflow_evt,
        output tx_active, rx_active, tx_clear, rx_clear,
        output tx_underrun_flag, tx_overflow_flag, rx_overflow_flag
    );
endinterface

// ===== core/ctl_regs.sv
// chip and queue control register group behind the bulk pipes
`timescale 1ns/1ps
module ctl_regs (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [7:0] irq_raw,
    output logic [7:0] irq_source_gate,
    output logic [7:0] irq_status_flags,
    input wire logic iso_crc_bad,
    output logic iso_out_crc_error_flag,
    input wire logic [2:0] tx_underrun_evt,
    input wire logic [2:0] tx_overflow_evt,
    input wire logic [2:0] rx_overflow_evt,
    output logic [2:0] tx_queue_clear,
    output logic [2:0] rx_queue_clear,
    output logic [2:0] tx_queue_enable,
    output logic [2:0] rx_queue_enable,
    output logic [2:0] tx_fill_ones,
    output logic [2:0] tx_underrun_flag,
    output logic [2:0] tx_overflow_flag,
    output logic [2:0] rx_overflow_flag,
    output logic chip_reset_hold,
    output logic digital_loop_bit,
    output logic remote_loop_bit,
    output logic [1:0] phase_comp_select,
    output logic [7:0] phase_delay_cycles
);
    // =========================================================
    // decode
    // =========================================================
    logic soft_chip_reset;
    logic wr_mask;
    logic wr_d_cmd;
    logic wr_b_cmd;
    logic wr_phase;
    logic d_act;
    logic b_act;
    logic [3:0] d_nib;
    logic [3:0] b1_nib;
    logic [3:0] b2_nib;

    function automatic logic [7:0] phase_cycles(input logic [1:0] sel);
        logic [7:0] c;
        c = 8'h00;
        if (sel == 2'h1) begin
            c = ctl_regs_pkg::PHASE_1_CYC;
        end else if (sel == 2'h2) begin
            c = ctl_regs_pkg::PHASE_2_CYC;
        end else if (sel == 2'h3) begin
            c = ctl_regs_pkg::PHASE_3_CYC;
        end
        return c;
    endfunction

    always_comb begin
        wr_mask = 1'b0;
        wr_d_cmd = 1'b0;
        wr_b_cmd = 1'b0;
        wr_phase = 1'b0;
        if (reg_wr) begin
            if (reg_addr == ctl_regs_pkg::OFS_IRQ_SOURCE_GATE) begin
                wr_mask = 1'b1;
            end else if (reg_addr == ctl_regs_pkg::OFS_D_CHANNEL_COMMAND) begin
                wr_d_cmd = 1'b1;
            end else if (reg_addr == ctl_regs_pkg::OFS_B_CHANNEL_COMMAND) begin
                wr_b_cmd = 1'b1;
            end else if (reg_addr
                == ctl_regs_pkg::OFS_OUTPUT_PHASE_CONTROL) begin
                wr_phase = 1'b1;
            end
        end
    end

    // no strobe acts while the chip is held in soft reset
    assign d_act = wr_d_cmd && !soft_chip_reset;
    assign b_act = wr_b_cmd && !soft_chip_reset;
    // zero bits give zero strobes, so nothing else is touched
    assign d_nib = d_act ? reg_wdata[7:4] : 4'h0;
    assign b1_nib = b_act
        ? reg_wdata[ctl_regs_pkg::FIRST_B_NIBBLE +: 4] : 4'h0;
    assign b2_nib = b_act
        ? reg_wdata[ctl_regs_pkg::SECOND_B_NIBBLE +: 4] : 4'h0;

    // =========================================================
    // soft reset
    // =========================================================
    // usb side (this register port) keeps running through it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            soft_chip_reset <= 1'b0;
        end else if (wr_d_cmd) begin
            soft_chip_reset <=
                reg_wdata[ctl_regs_pkg::SOFT_RESET_BIT];
        end
    end
    assign chip_reset_hold = soft_chip_reset;

    // =========================================================
    // configuration registers
    // =========================================================
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_source_gate <= ctl_regs_pkg::RST_IRQ_SOURCE_GATE;
        end else if (soft_chip_reset) begin
            irq_source_gate <= ctl_regs_pkg::RST_IRQ_SOURCE_GATE;
        end else if (wr_mask) begin
            irq_source_gate <= reg_wdata;
        end
    end

    // a masked source never reaches the status view
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_status_flags <= 8'h00;
        end else begin
            irq_status_flags <= irq_raw & ~irq_source_gate;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_comp_select <= ctl_regs_pkg::RST_PHASE_COMP;
        end else if (soft_chip_reset) begin
            phase_comp_select <= ctl_regs_pkg::RST_PHASE_COMP;
        end else if (wr_phase) begin
            phase_comp_select <= reg_wdata[ctl_regs_pkg::PHASE_LSB +:
                ctl_regs_pkg::PHASE_W];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_delay_cycles <= 8'h00;
        end else begin
            phase_delay_cycles <= phase_cycles(phase_comp_select);
        end
    end

    // loops only leave on soft or pin reset, never on a zero write
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            digital_loop_bit <= 1'b0;
            remote_loop_bit <= 1'b0;
        end else if (soft_chip_reset) begin
            digital_loop_bit <= 1'b0;
            remote_loop_bit <= 1'b0;
        end else if (d_act) begin
            if (reg_wdata[ctl_regs_pkg::DIGITAL_LOOP_BIT]) begin
                digital_loop_bit <= 1'b1;
            end
            if (reg_wdata[ctl_regs_pkg::REMOTE_LOOP_BIT]) begin
                remote_loop_bit <= 1'b1;
            end
        end
    end

    // a crc error in the same cycle as the clear keeps the flag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            iso_out_crc_error_flag <= 1'b0;
        end else if (soft_chip_reset) begin
            iso_out_crc_error_flag <= 1'b0;
        end else if (iso_crc_bad) begin
            iso_out_crc_error_flag <= 1'b1;
        end else if (d_act && reg_wdata[ctl_regs_pkg::ISO_CLEAR_BIT]) begin
            iso_out_crc_error_flag <= 1'b0;
        end
    end

    // =========================================================
    // read port
    // =========================================================
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                if (reg_addr == ctl_regs_pkg::OFS_IRQ_SOURCE_GATE) begin
                    reg_rdata <= irq_source_gate;
                end else if (reg_addr
                    == ctl_regs_pkg::OFS_OUTPUT_PHASE_CONTROL) begin
                    reg_rdata <= {6'h00, phase_comp_select};
                end else begin
                    reg_rdata <= 8'h00;
                end
            end
        end
    end

    // =========================================================
    // channel units: 0 d, 1 b1, 2 b2
    // =========================================================
    chan_ctl_if ch[ctl_regs_pkg::NUM_CH] ();
    logic [3:0] nib[ctl_regs_pkg::NUM_CH];
    assign nib[ctl_regs_pkg::CH_D] = d_nib;
    assign nib[ctl_regs_pkg::CH_B1] = b1_nib;
    assign nib[ctl_regs_pkg::CH_B2] = b2_nib;

    for (genvar i = 0; i < ctl_regs_pkg::NUM_CH; i++) begin : g_ch
        assign ch[i].tx_rst = nib[i][ctl_regs_pkg::NIB_TX_RESET];
        assign ch[i].rx_rst = nib[i][ctl_regs_pkg::NIB_RX_RESET];
        assign ch[i].tx_en = nib[i][ctl_regs_pkg::NIB_TX_ENABLE];
        assign ch[i].rx_en = nib[i][ctl_regs_pkg::NIB_RX_ENABLE];
        assign ch[i].hold = soft_chip_reset;
        assign ch[i].tx_underrun_evt = tx_underrun_evt[i];
        assign ch[i].tx_overflow_evt = tx_overflow_evt[i];
        assign ch[i].rx_overflow_evt = rx_overflow_evt[i];
        assign tx_queue_enable[i] = ch[i].tx_active;
        assign rx_queue_enable[i] = ch[i].rx_active;
        // idle transmitter sends all-ones fill
        assign tx_fill_ones[i] = !ch[i].tx_active;
        assign tx_queue_clear[i] = ch[i].tx_clear;
        assign rx_queue_clear[i] = ch[i].rx_clear;
        assign tx_underrun_flag[i] = ch[i].tx_underrun_flag;
        assign tx_overflow_flag[i] = ch[i].tx_overflow_flag;
        assign rx_overflow_flag[i] = ch[i].rx_overflow_flag;
        queue_ctrl u_queue (
            .clk(clk),
            .rst_b(rst_b),
            .bus(ch[i])
        );
    end

    // =========================================================
    // checks
    // =========================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_mask_read_back: assert property (
        (reg_rd && reg_addr == ctl_regs_pkg::OFS_IRQ_SOURCE_GATE)
        |=> reg_rvalid && reg_rdata == $past(irq_source_gate))
        else $error("mask read returned wrong value");

    a_status_masked: assert property (
        ##1 irq_status_flags == ($past(irq_raw) & ~$past(irq_source_gate)))
        else $error("masked source leaked to status");

    a_cmd_reads_zero: assert property (
        (reg_rd && (reg_addr == ctl_regs_pkg::OFS_D_CHANNEL_COMMAND
            || reg_addr == ctl_regs_pkg::OFS_B_CHANNEL_COMMAND))
        |=> reg_rdata == 8'h00)
        else $error("command register read not zero");

    a_iso_set_wins: assert property (
        (iso_crc_bad && !soft_chip_reset) |=> iso_out_crc_error_flag)
        else $error("crc error flag not raised");

    a_iso_clear_strobe: assert property (
        (d_act && reg_wdata[ctl_regs_pkg::ISO_CLEAR_BIT] && !iso_crc_bad)
        |=> !iso_out_crc_error_flag)
        else $error("iso clear strobe ignored");

    a_loop_sticky: assert property (
        (digital_loop_bit && !soft_chip_reset)
        |=> digital_loop_bit)
        else $error("digital loop dropped without soft reset");

    a_remote_loop_sticky: assert property (
        (remote_loop_bit && !soft_chip_reset) |=> remote_loop_bit)
        else $error("remote loop dropped without soft reset");

    a_d_tx_enable: assert property (
        (d_act && reg_wdata[5] && reg_wdata[7:6] == 2'h0
            && !tx_underrun_evt[0] && !tx_overflow_evt[0])
        |=> tx_queue_enable[0])
        else $error("d tx enable strobe ignored");

    a_b1_tx_reset: assert property (
        (b_act && reg_wdata[7] && !reg_wdata[5])
        |=> !tx_queue_enable[1] && tx_queue_clear[1])
        else $error("b1 tx reset strobe ignored");

    a_soft_reset_clears: assert property (
        soft_chip_reset |=> !digital_loop_bit && !remote_loop_bit
            && irq_source_gate == ctl_regs_pkg::RST_IRQ_SOURCE_GATE
            && tx_queue_enable == 3'h0)
        else $error("soft reset did not restore state");

    a_soft_reset_held: assert property (
        (soft_chip_reset && !wr_d_cmd) |=> soft_chip_reset)
        else $error("soft reset cleared itself");

    a_phase_delay: assert property (
        (wr_phase && !soft_chip_reset && reg_wdata[1:0] == 2'h3)
        |=> ##1 phase_delay_cycles == ctl_regs_pkg::PHASE_3_CYC)
        else $error("phase delay count wrong");

    c_d_reset_enable: cover property (
        d_act && reg_wdata[7] && reg_wdata[5] ##2 tx_queue_enable[0]);
    c_soft_reset_exit: cover property (
        soft_chip_reset ##[1:20] !soft_chip_reset);
    c_iso_clear: cover property (
        iso_out_crc_error_flag ##1 !iso_out_crc_error_flag);
    c_b2_underrun: cover property (tx_underrun_flag[2]);
endmodule

// ===== core/ctl_regs_pkg.sv
// constants for the chip and queue control register group
// How it works
// - mask resets E1h; a one blocks that source
// - command bits: one acts, zero does nothing, except soft reset bit, where zero leaves soft reset
// - d tx reset clears queue, idles, sends ones
// - d rx reset clears queue, stays idle
// - reset strobe finishes before accompanying enables
// - d tx enable starts queue, reads zero
// - d rx enable starts queue, reads zero
// - soft reset acts as pin reset, bus kept
// - soft reset held until software writes zero
// - iso clear strobe drops crc error flag
// - digital loop stays set until soft reset
// - remote loop returns b channels, until reset
// - b command: same strobes for b1, b2
// - phase field selects 0/260/520/1040 ns
// - iso flag set on crc error, sticky
// - underrun/overflow disable queue; enable clears flag
// - host uses bulk out writes, bulk in reads
package ctl_regs_pkg;
    // register offsets
    localparam logic [7:0] OFS_IRQ_SOURCE_GATE = 8'h00;
    localparam logic [7:0] OFS_D_CHANNEL_COMMAND = 8'h01;
    localparam logic [7:0] OFS_B_CHANNEL_COMMAND = 8'h02;
    localparam logic [7:0] OFS_OUTPUT_PHASE_CONTROL = 8'h03;
    // reset values
    localparam logic [7:0] RST_IRQ_SOURCE_GATE = 8'hE1;
    localparam logic [1:0] RST_PHASE_COMP = 2'h0;
    // d command bit positions
    localparam int D_TX_RESET_BIT = 7;
    localparam int D_RX_RESET_BIT = 6;
    localparam int D_TX_ENABLE_BIT = 5;
    localparam int D_RX_ENABLE_BIT = 4;
    localparam int SOFT_RESET_BIT = 3;
    localparam int ISO_CLEAR_BIT = 2;
    localparam int DIGITAL_LOOP_BIT = 1;
    localparam int REMOTE_LOOP_BIT = 0;
    // b command nibble positions, strobe order inside a nibble
    localparam int FIRST_B_NIBBLE = 4;
    localparam int SECOND_B_NIBBLE = 0;
    localparam int NIB_TX_RESET = 3;
    localparam int NIB_RX_RESET = 2;
    localparam int NIB_TX_ENABLE = 1;
    localparam int NIB_RX_ENABLE = 0;
    // phase field
    localparam int PHASE_LSB = 0;
    localparam int PHASE_W = 2;
    // timing
    localparam int CLK_PERIOD_PS = 8000;
    localparam int PHASE_1_NS = 260;
    localparam int PHASE_2_NS = 520;
    localparam int PHASE_3_NS = 1040;
    localparam logic [7:0] PHASE_1_CYC =
        8'((PHASE_1_NS * 1000) / CLK_PERIOD_PS);
    localparam logic [7:0] PHASE_2_CYC =
        8'((PHASE_2_NS * 1000) / CLK_PERIOD_PS);
    localparam logic [7:0] PHASE_3_CYC =
        8'((PHASE_3_NS * 1000) / CLK_PERIOD_PS);
    // channel indices
    localparam int CH_D = 0;
    localparam int CH_B1 = 1;
    localparam int CH_B2 = 2;
    localparam int NUM_CH = 3;

    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_CLEAR = 1'b1
    } seq_e;
endpackage

// ===== core/queue_ctrl.sv
// per channel queue reset/enable sequencer with error flags
`timescale 1ns/1ps
module queue_ctrl (
    input wire logic clk,
    input wire logic rst_b,
    chan_ctl_if.unit bus
);
    ctl_regs_pkg::seq_e state;
    logic pend_tx_en;
    logic pend_rx_en;
    logic go_tx;
    logic go_rx;

    // =========================================================
    // sequencing
    // =========================================================
    // enables take effect only once any reset in flight is done
    always_comb begin
        go_tx = 1'b0;
        go_rx = 1'b0;
        if (state == ctl_regs_pkg::SEQ_CLEAR) begin
            go_tx = pend_tx_en | bus.tx_en;
            go_rx = pend_rx_en | bus.rx_en;
        end else if (!(bus.tx_rst || bus.rx_rst)) begin
            go_tx = bus.tx_en;
            go_rx = bus.rx_en;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ctl_regs_pkg::SEQ_IDLE;
            pend_tx_en <= 1'b0;
            pend_rx_en <= 1'b0;
        end else if (bus.hold) begin
            state <= ctl_regs_pkg::SEQ_IDLE;
            pend_tx_en <= 1'b0;
            pend_rx_en <= 1'b0;
        end else begin
            case (state)
                ctl_regs_pkg::SEQ_IDLE: begin
                    if (bus.tx_rst || bus.rx_rst) begin
                        state <= ctl_regs_pkg::SEQ_CLEAR;
                        pend_tx_en <= bus.tx_en;
                        pend_rx_en <= bus.rx_en;
                    end
                end
                default: begin
                    state <= ctl_regs_pkg::SEQ_IDLE;
                    pend_tx_en <= 1'b0;
                    pend_rx_en <= 1'b0;
                end
            endcase
        end
    end

    // =========================================================
    // transmit side
    // =========================================================
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus.tx_active <= 1'b0;
            bus.tx_clear <= 1'b0;
        end else if (bus.hold) begin
            bus.tx_active <= 1'b0;
            bus.tx_clear <= 1'b1;
        end else begin
            // an error also empties the queue, as a reset would
            bus.tx_clear <= bus.tx_rst
                || (bus.tx_active
                    && (bus.tx_underrun_evt || bus.tx_overflow_evt));
            if (bus.tx_rst && state == ctl_regs_pkg::SEQ_IDLE) begin
                bus.tx_active <= 1'b0;
            end else if (bus.tx_active
                && (bus.tx_underrun_evt || bus.tx_overflow_evt)) begin
                bus.tx_active <= 1'b0;
            end else if (go_tx) begin
                bus.tx_active <= 1'b1;
            end
        end
    end

    // set wins over the clear done by a new enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus.tx_underrun_flag <= 1'b0;
            bus.tx_overflow_flag <= 1'b0;
        end else if (bus.hold) begin
            bus.tx_underrun_flag <= 1'b0;
            bus.tx_overflow_flag <= 1'b0;
        end else begin
            if (bus.tx_active && bus.tx_underrun_evt) begin
                bus.tx_underrun_flag <= 1'b1;
            end else if (go_tx) begin
                bus.tx_underrun_flag <= 1'b0;
            end
            if (bus.tx_active && bus.tx_overflow_evt) begin
                bus.tx_overflow_flag <= 1'b1;
            end else if (go_tx) begin
                bus.tx_overflow_flag <= 1'b0;
            end
        end
    end

    // =========================================================
    // receive side
    // =========================================================
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus.rx_active <= 1'b0;
            bus.rx_clear <= 1'b0;
            bus.rx_overflow_flag <= 1'b0;
        end else if (bus.hold) begin
            bus.rx_active <= 1'b0;
            bus.rx_clear <= 1'b1;
            bus.rx_overflow_flag <= 1'b0;
        end else begin
            bus.rx_clear <= bus.rx_rst
                || (bus.rx_active && bus.rx_overflow_evt);
            if (bus.rx_rst && state == ctl_regs_pkg::SEQ_IDLE) begin
                bus.rx_active <= 1'b0;
            end else if (bus.rx_active && bus.rx_overflow_evt) begin
                bus.rx_active <= 1'b0;
            end else if (go_rx) begin
                bus.rx_active <= 1'b1;
            end
            if (bus.rx_active && bus.rx_overflow_evt) begin
                bus.rx_overflow_flag <= 1'b1;
            end else if (go_rx) begin
                bus.rx_overflow_flag <= 1'b0;
            end
        end
    end

    // =========================================================
    // checks
    // =========================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b || bus.hold);

    a_reset_then_enable: assert property (
        (state == ctl_regs_pkg::SEQ_IDLE && bus.tx_rst && bus.tx_en)
        |=> (!bus.tx_active && bus.tx_clear) ##1 bus.tx_active)
        else $error("tx enable not applied after reset finished");
    a_rx_reset_idle: assert property (
        (state == ctl_regs_pkg::SEQ_IDLE && bus.rx_rst && !bus.rx_en)
        |=> !bus.rx_active && bus.rx_clear ##1 !bus.rx_active)
        else $error("rx queue active after lone reset");
    a_underrun_stops_queue: assert property (
        (bus.tx_active && bus.tx_underrun_evt)
        |=> !bus.tx_active && bus.tx_underrun_flag)
        else $error("underrun did not stop queue and flag");
endmodule

// ===== verification/host_model.sv
// host side model issuing register writes and reads
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    // ====================
    // bus cycles
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // released lines show the inverse so stale values never pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        n = 0;
        #1;
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
    endtask
    // soft reset always written alone, left by writing zero
    task automatic soft_rst(input logic on);
        wr(8'h01, on ? 8'h08 : 8'h00);
    endtask
endmodule

// ===== verification/testbench.sv
// self-checking bench for the control register group
`timescale 1ns/1ps
module testbench;
    localparam logic [7:0] MK = 8'h00;
    localparam logic [7:0] DC = 8'h01;
    localparam logic [7:0] BC = 8'h02;
    localparam logic [7:0] PH = 8'h03;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] irq_raw = 8'h00;
    logic iso_crc_bad = 1'b0;
    logic [2:0] tx_underrun_evt = 3'h0;
    logic [2:0] tx_overflow_evt = 3'h0;
    logic [2:0] rx_overflow_evt = 3'h0;
    logic reg_wr, reg_rd, reg_rvalid, iso_out_crc_error_flag;
    logic chip_reset_hold, digital_loop_bit, remote_loop_bit;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, irq_status_flags, pdly, rv;
    logic [2:0] tx_clr, tx_en, rx_en, tx_fill_ones, tx_underrun_flag;
    logic [1:0] psel;
    logic [7:0] gate;
    logic [2:0] rx_clr, tx_ovf, rx_ovf;
    int error_cnt = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [7:0] dly [4] = '{8'h00, ctl_regs_pkg::PHASE_1_CYC,
        ctl_regs_pkg::PHASE_2_CYC, ctl_regs_pkg::PHASE_3_CYC};
    always #4 clk = ~clk;
    ctl_regs ctl_regs_inst (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .irq_raw(irq_raw),
        .irq_source_gate(gate), .irq_status_flags(irq_status_flags),
        .iso_crc_bad(iso_crc_bad),
        .iso_out_crc_error_flag(iso_out_crc_error_flag),
        .tx_underrun_evt(tx_underrun_evt), .tx_overflow_evt(tx_overflow_evt),
        .rx_overflow_evt(rx_overflow_evt), .tx_queue_clear(tx_clr),
        .rx_queue_clear(rx_clr), .tx_queue_enable(tx_en),
        .rx_queue_enable(rx_en),
        .tx_fill_ones(tx_fill_ones), .tx_underrun_flag(tx_underrun_flag),
        .tx_overflow_flag(tx_ovf), .rx_overflow_flag(rx_ovf),
        .chip_reset_hold(chip_reset_hold), .digital_loop_bit(digital_loop_bit),
        .remote_loop_bit(remote_loop_bit), .phase_comp_select(psel),
        .phase_delay_cycles(pdly));
    host_model host_model_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));
    // ====================
    // helpers
    task automatic chk(input string s, input logic [7:0] e,
        input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic summarize();
        if (error_cnt == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        host_model_inst.wr(a, d);
        #1;
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            summarize();
        end
    end
    // ====================
    // scenarios
    task automatic t_reset_mask();
        host_model_inst.rd(MK, rv);
        chk("mask", 8'hE1, rv);
        host_model_inst.rd(8'h7F, rv);
        chk("unmapped", 8'h00, rv);
        chk("fill", 8'h07, {5'h0, tx_fill_ones});
        @(posedge clk);
        irq_raw <= 8'hE0;
        w(MK, 8'h60);
        tick();
        tick();
        chk("status", 8'h80, irq_status_flags);
        chk("gate", 8'h60, gate);
    endtask
    task automatic t_dchan();
        w(DC, 8'hA0);
        chk("clr", 8'h10, {1'b0, tx_clr, 1'b0, tx_en});
        tick();
        chk("en", 8'h61, {1'b0, tx_fill_ones, 1'b0, tx_en});
        w(DC, 8'h10);
        w(DC, 8'h00);
        chk("keep", 8'h11, {1'b0, rx_en, 1'b0, tx_en});
        w(DC, 8'h40);
        chk("rxclr", 8'h01, {5'h0, rx_clr});
        tick();
        chk("rxrst", 8'h01, {1'b0, rx_en, 1'b0, tx_en});
        host_model_inst.rd(DC, rv);
        chk("cmdrd", 8'h00, rv);
        @(posedge clk);
        tx_underrun_evt <= 3'h1;
        @(posedge clk);
        tx_underrun_evt <= 3'h0;
        #1;
        chk("unrun", 8'h10, {1'b0, tx_underrun_flag, 1'b0, tx_en});
        w(DC, 8'h20);
        chk("reen", 8'h01, {1'b0, tx_underrun_flag, 1'b0, tx_en});
    endtask
    task automatic t_iso_b();
        @(posedge clk);
        iso_crc_bad <= 1'b1;
        @(posedge clk);
        iso_crc_bad <= 1'b0;
        #1;
        chk("iso", 8'h01, {7'h0, iso_out_crc_error_flag});
        w(DC, 8'h04);
        chk("isoclr", 8'h00, {7'h0, iso_out_crc_error_flag});
        w(BC, 8'h23);
        chk("ben", 8'h07, {5'h0, tx_en});
        w(BC, 8'h80);
        chk("brst", 8'h25, {1'b0, tx_clr, 1'b0, tx_en});
        @(posedge clk);
        tx_overflow_evt <= 3'h4;
        rx_overflow_evt <= 3'h4;
        @(posedge clk);
        tx_overflow_evt <= 3'h0;
        rx_overflow_evt <= 3'h0;
        #1;
        chk("ovf", 8'h44, {1'b0, tx_ovf, 1'b0, rx_ovf});
        chk("ovfen", 8'h01, {1'b0, rx_en, 1'b0, tx_en});
    endtask
    task automatic t_loop_phase();
        w(DC, 8'h03);
        w(DC, 8'h00);
        chk("loops", 8'h03,
            {6'h0, digital_loop_bit, remote_loop_bit});
        for (int i = 0; i < 4; i++) begin
            w(PH, 8'(i));
            tick();
            chk("psel", 8'(i), {6'h0, psel});
            chk("pdly", dly[i], pdly);
        end
    endtask
    task automatic t_soft();
        host_model_inst.soft_rst(1'b1);
        tick();
        chk("hold", 8'h01, {7'h0, chip_reset_hold});
        chk("lp", 8'h00,
            {digital_loop_bit, remote_loop_bit, tx_en, rx_en});
        chk("sflg", 8'h00, {2'h0, tx_ovf, rx_ovf});
        host_model_inst.rd(MK, rv);
        chk("smask", 8'hE1, rv);
        host_model_inst.rd(PH, rv);
        chk("sph", 8'h00, rv);
        host_model_inst.soft_rst(1'b0);
        tick();
        chk("leave", 8'h00, {7'h0, chip_reset_hold});
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_reset_mask();
        t_dchan();
        t_iso_b();
        t_loop_phase();
        t_soft();
        summarize();
    end
endmodule
